// file: logic/adcseq_top.sv
// conversion sequencer with its wishbone register file
// How it works
// - go bit or selected trigger starts conversion
// - completion clears go, sets flag, loads result
// - sleep conversion only with rc clock
// - rc clock delays start one instruction
// - sleep completion with irq enable wakes
// - sleep completion without irq powers down
// - other clocks abort conversion on sleep
// - sleep trigger remembered, runs after wake
// - rising trigger edge sets go bit
// - trigger select field picks the source
// - clock codes x11 pick rc clock
// - trigger codes: off, pin, result read
// - alignment bit picks right or left result
//
// The Wishbone interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ns
`default_nettype none
module adcseq_top (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [9:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [8:0] trig_in,
	input wire logic sleep_i,
	input wire logic conv_done_i,
	input wire logic [9:0] conv_result_i,
	output logic adc_power_o,
	output logic conv_start_o,
	output logic conv_abort_o,
	output logic rc_clock_sel_o,
	output logic [5:0] channel_select_o,
	output logic [1:0] positive_ref_select_o,
	output logic wake_req_o
);

	// ****************************************
	// declarations
	// ****************************************
	logic [7:0] ctrl0_q;
	logic [7:0] ctrl1_q;
	logic [3:0] trig_sel_q;
	logic [15:0] result_q;
	logic done_q;
	logic irqen_q;
	logic pend_q;
	logic pd_q;
	logic ack_q;
	logic [31:0] dat_q;
	logic start_q;
	logic abort_q;
	logic wake_q;
	logic power_q;
	logic rc_q;
	logic [2:0] dly_q;
	adcseq_pkg::adcseq_state_t state_q;
	logic [7:0] idx;
	logic wr_ev;
	logic rd_ev;
	logic on;
	logic rc;
	logic trig_edge;
	logic done_ev;
	logic abort_ev;
	logic hold_off;
	logic trig_go;
	logic [15:0] fmt_res;

	// ****************************************
	// bus decode
	// ****************************************
	assign idx = wb_adr_i[9:2];
	// write and read take effect at the edge where ack is sampled
	assign wr_ev = wb_cyc_i && wb_stb_i && ack_q && wb_we_i && wb_sel_i[0];
	assign rd_ev = wb_cyc_i && wb_stb_i && ack_q && !wb_we_i;

	// ****************************************
	// control decode
	// ****************************************
	assign on = ctrl0_q[adcseq_pkg::CTRL0_ON];
	// clock codes ending in 11 select the rc clock
	assign rc = ctrl1_q[adcseq_pkg::CTRL1_CS_LSB +: 2] == adcseq_pkg::CS_RC_LOW;
	assign done_ev = state_q == adcseq_pkg::ST_CONV && conv_done_i;
	// sleep on a system-derived clock kills the conversion
	assign hold_off = sleep_i && !rc;
	assign abort_ev = hold_off && state_q != adcseq_pkg::ST_IDLE;
	assign trig_go = trig_edge && on && !sleep_i;
	// result placement by alignment bit
	assign fmt_res = ctrl1_q[adcseq_pkg::CTRL1_ALIGN] ?
		{6'h00, conv_result_i} : {conv_result_i, 6'h00};

	// read mux for the register file
	function automatic logic [7:0] rd_mux(
		input logic [7:0] i,
		input logic [7:0] c0,
		input logic [7:0] c1,
		input logic [3:0] tg,
		input logic [15:0] rs,
		input logic dn,
		input logic ie
	);
		logic [7:0] r;
		r = 8'h00;
		case (i)
			adcseq_pkg::IDX_RES_LOW: r = rs[7:0];
			adcseq_pkg::IDX_RES_HIGH: r = rs[15:8];
			adcseq_pkg::IDX_CTRL0: r = c0;
			adcseq_pkg::IDX_CTRL1: r = c1 & adcseq_pkg::CTRL1_MASK;
			adcseq_pkg::IDX_TRIG: r = {4'h0, tg};
			adcseq_pkg::IDX_STAT: r = {6'h00, ie, dn};
			default: r = 8'h00;
		endcase
		return r;
	endfunction

	// ****************************************
	// trigger selection
	// ****************************************
	adcseq_trig u_trig (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.trigger_select(trig_sel_q),
		.trig_in(trig_in),
		.res_high_read(rd_ev && idx == adcseq_pkg::IDX_RES_HIGH),
		.trig_edge(trig_edge)
	);

	// ****************************************
	// wishbone slave
	// ****************************************
	// ack one cycle after request, dropped the cycle after
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
		end
	end

	// read data loaded as ack rises, zero for unmapped
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			dat_q <= 32'h0000_0000;
		end else if (wb_cyc_i && wb_stb_i && !ack_q) begin
			dat_q <= {24'h00_0000, rd_mux(idx, ctrl0_q, ctrl1_q, trig_sel_q,
				result_q, done_q, irqen_q)};
		end
	end

	// ****************************************
	// configuration registers
	// ****************************************
	// clock, format and reference controls, trigger select and irq enable
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl1_q <= adcseq_pkg::RST_CTRL1;
			trig_sel_q <= adcseq_pkg::RST_TRIG;
			irqen_q <= 1'b0;
		end else if (wr_ev) begin
			if (idx == adcseq_pkg::IDX_CTRL1) begin
				ctrl1_q <= wb_dat_i[7:0] & adcseq_pkg::CTRL1_MASK;
			end
			if (idx == adcseq_pkg::IDX_TRIG) begin
				trig_sel_q <= wb_dat_i[3:0] & adcseq_pkg::TRIG_MASK;
			end
			if (idx == adcseq_pkg::IDX_STAT) begin
				irqen_q <= wb_dat_i[adcseq_pkg::STAT_IRQEN];
			end
		end
	end

	// channel, enable and go bit; hardware set wins over clear
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl0_q <= adcseq_pkg::RST_CTRL0;
		end else begin
			if (wr_ev && idx == adcseq_pkg::IDX_CTRL0) begin
				ctrl0_q[7:2] <= wb_dat_i[7:2];
				ctrl0_q[adcseq_pkg::CTRL0_ON] <= wb_dat_i[adcseq_pkg::CTRL0_ON];
				// go only sticks with the converter enabled
				ctrl0_q[adcseq_pkg::CTRL0_GO] <= wb_dat_i[adcseq_pkg::CTRL0_GO] &&
					wb_dat_i[adcseq_pkg::CTRL0_ON];
			end else if (done_ev || abort_ev || !on) begin
				ctrl0_q[adcseq_pkg::CTRL0_GO] <= 1'b0;
			end
			if (trig_go || (pend_q && on && !sleep_i)) begin
				ctrl0_q[adcseq_pkg::CTRL0_GO] <= 1'b1;
			end
		end
	end

	// ****************************************
	// result and done flag
	// ****************************************
	// completion loads result; software writes land unshifted
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			result_q <= adcseq_pkg::RST_RESULT;
		end else if (done_ev) begin
			result_q <= fmt_res;
		end else if (wr_ev && idx == adcseq_pkg::IDX_RES_LOW) begin
			result_q[7:0] <= wb_dat_i[7:0];
		end else if (wr_ev && idx == adcseq_pkg::IDX_RES_HIGH) begin
			result_q[15:8] <= wb_dat_i[7:0];
		end
	end

	// done flag: set by completion, cleared only by a zero write
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			done_q <= 1'b0;
		end else if (done_ev) begin
			done_q <= 1'b1;
		end else if (wr_ev && idx == adcseq_pkg::IDX_STAT &&
			!wb_dat_i[adcseq_pkg::STAT_DONE]) begin
			done_q <= 1'b0;
		end
	end

	// ****************************************
	// sleep handling
	// ****************************************
	// one pending flag for triggers seen while asleep
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pend_q <= 1'b0;
		end else if (trig_edge && on && sleep_i) begin
			pend_q <= 1'b1;
		end else if (!sleep_i || !on) begin
			pend_q <= 1'b0;
		end
	end

	// converter powered down until sleep ends
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pd_q <= 1'b0;
		end else if (!sleep_i) begin
			pd_q <= 1'b0;
		end else if ((done_ev && !irqen_q) || abort_ev) begin
			pd_q <= 1'b1;
		end
	end

	// ****************************************
	// sequencer
	// ****************************************
	// idle, rc start delay, converting
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= adcseq_pkg::ST_IDLE;
			dly_q <= 3'h0;
		end else begin
			case (state_q)
				adcseq_pkg::ST_IDLE: begin
					dly_q <= 3'h0;
					if (ctrl0_q[adcseq_pkg::CTRL0_GO] && on && !hold_off) begin
						state_q <= rc ? adcseq_pkg::ST_DELAY : adcseq_pkg::ST_CONV;
					end
				end
				adcseq_pkg::ST_DELAY: begin
					dly_q <= dly_q + 3'h1;
					if (abort_ev || !ctrl0_q[adcseq_pkg::CTRL0_GO]) begin
						state_q <= adcseq_pkg::ST_IDLE;
					end else if (dly_q == 3'(adcseq_pkg::INSTR_CYC - 1)) begin
						state_q <= adcseq_pkg::ST_CONV;
					end
				end
				adcseq_pkg::ST_CONV: begin
					if (done_ev || abort_ev || !ctrl0_q[adcseq_pkg::CTRL0_GO]) begin
						state_q <= adcseq_pkg::ST_IDLE;
					end
				end
				default: state_q <= adcseq_pkg::ST_IDLE;
			endcase
		end
	end

	// ****************************************
	// core strobes and pins
	// ****************************************
	// start pulse on entering conversion, abort pulse on leaving early
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			start_q <= 1'b0;
			abort_q <= 1'b0;
			wake_q <= 1'b0;
		end else begin
			start_q <= (state_q == adcseq_pkg::ST_IDLE && ctrl0_q[adcseq_pkg::CTRL0_GO]
				&& on && !hold_off && !rc) || (state_q == adcseq_pkg::ST_DELAY &&
				!abort_ev && ctrl0_q[adcseq_pkg::CTRL0_GO] &&
				dly_q == 3'(adcseq_pkg::INSTR_CYC - 1));
			abort_q <= state_q != adcseq_pkg::ST_IDLE && !done_ev &&
				(abort_ev || !ctrl0_q[adcseq_pkg::CTRL0_GO]);
			wake_q <= done_ev && sleep_i && irqen_q;
		end
	end

	// analog power and configuration pins
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			power_q <= 1'b0;
			rc_q <= 1'b0;
		end else begin
			power_q <= on && !pd_q && !hold_off;
			rc_q <= rc;
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = dat_q;
	assign conv_start_o = start_q;
	assign conv_abort_o = abort_q;
	assign wake_req_o = wake_q;
	assign adc_power_o = power_q;
	assign rc_clock_sel_o = rc_q;
	assign channel_select_o = ctrl0_q[7:2];
	assign positive_ref_select_o = ctrl1_q[1:0];

	// ****************************************
	// checks
	// ****************************************
	sequence s_rc_go;
		state_q == adcseq_pkg::ST_IDLE && ctrl0_q[adcseq_pkg::CTRL0_GO] &&
			on && rc && !sleep_i;
	endsequence

	sequence s_rc_wait;
		(state_q == adcseq_pkg::ST_DELAY && !conv_start_o)[*4] ##1 conv_start_o;
	endsequence

	done_clears_go_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		done_ev |=> done_q && !ctrl0_q[adcseq_pkg::CTRL0_GO])
		else $error("completion left go set or flag clear");

	right_align_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		done_ev && ctrl1_q[adcseq_pkg::CTRL1_ALIGN] |=>
			result_q == {6'h00, $past(conv_result_i)})
		else $error("right aligned result wrong");

	rc_start_delay_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		s_rc_go |=> s_rc_wait)
		else $error("rc start not delayed one instruction");

	sleep_abort_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		sleep_i && !rc && state_q == adcseq_pkg::ST_CONV && !done_ev |=>
			conv_abort_o && !ctrl0_q[adcseq_pkg::CTRL0_GO] && $stable(on))
		else $error("sleep did not abort conversion");

	sleep_pend_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		trig_edge && on && sleep_i |=> pend_q)
		else $error("sleep trigger not remembered");

	pend_resume_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		pend_q && on && !sleep_i |=> ctrl0_q[adcseq_pkg::CTRL0_GO] && !pend_q)
		else $error("pending trigger not resumed once");

	wake_req_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		done_ev && sleep_i && irqen_q |=> wake_req_o)
		else $error("no wake after sleep conversion");

	sleep_pdown_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		done_ev && sleep_i && !irqen_q ##1 sleep_i |=> !adc_power_o)
		else $error("converter still powered after sleep completion");

	trig_go_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		trig_go |=> ctrl0_q[adcseq_pkg::CTRL0_GO])
		else $error("trigger did not set go");

	off_idle_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!on && !wr_ev |=> !conv_start_o && !ctrl0_q[adcseq_pkg::CTRL0_GO])
		else $error("activity while converter disabled");

endmodule
`default_nettype wire

// file: logic/adcseq_trig.sv
// trigger source selector with rising edge detection
`timescale 1ns/1ns
`default_nettype none
module adcseq_trig (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [3:0] trigger_select,
	input wire logic [8:0] trig_in,
	input wire logic res_high_read,
	output logic trig_edge
);

	logic lvl;
	logic lvl_q;
	logic edge_q;

	// level of the selected external source, low for unused codes
	function automatic logic pick(input logic [3:0] sel, input logic [8:0] src);
		logic r;
		r = 1'b0;
		if (sel != adcseq_pkg::TRIG_OFF && sel <= adcseq_pkg::TRIG_LAST_EXT) begin
			r = src[sel - 4'h1];
		end
		return r;
	endfunction

	assign lvl = pick(trigger_select, trig_in);

	// previous level for edge detection
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			lvl_q <= 1'b0;
		end else begin
			lvl_q <= lvl;
		end
	end

	// rising edge or a read of the high result byte
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			edge_q <= 1'b0;
		end else begin
			edge_q <= (lvl && !lvl_q) ||
				(trigger_select == adcseq_pkg::TRIG_RES_READ && res_high_read);
		end
	end

	assign trig_edge = edge_q;

	trig_edge_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(lvl && !lvl_q) |=> trig_edge)
		else $error("rising trigger edge not passed on");

endmodule
`default_nettype wire

// file: pkg/adcseq_pkg.sv
// constants shared by the conversion sequencer and its trigger selector
package adcseq_pkg;

	// ****************************************
	// register indices (byte address = 4 * index)
	// ****************************************
	localparam logic [7:0] IDX_RES_LOW = 8'h9B;
	localparam logic [7:0] IDX_RES_HIGH = 8'h9C;
	localparam logic [7:0] IDX_CTRL0 = 8'h9D;
	localparam logic [7:0] IDX_CTRL1 = 8'h9E;
	localparam logic [7:0] IDX_TRIG = 8'h9F;
	localparam logic [7:0] IDX_STAT = 8'hA0;

	// ****************************************
	// field positions
	// ****************************************
	localparam int CTRL0_ON = 0;
	localparam int CTRL0_GO = 1;
	localparam int CTRL0_CHS_LSB = 2;
	localparam int CTRL1_ALIGN = 7;
	localparam int CTRL1_CS_LSB = 4;
	localparam int CTRL1_POSITIVE_REF_SELECT_LSB = 0;
	localparam int STAT_DONE = 0;
	localparam int STAT_IRQEN = 1;
	localparam logic [7:0] CTRL1_MASK = 8'hF3;
	localparam logic [3:0] TRIG_MASK = 4'hF;

	// ****************************************
	// reset values
	// ****************************************
	localparam logic [7:0] RST_CTRL0 = 8'h00;
	localparam logic [7:0] RST_CTRL1 = 8'h00;
	localparam logic [3:0] RST_TRIG = 4'h0;
	localparam logic [15:0] RST_RESULT = 16'h0000;

	// ****************************************
	// encodings
	// ****************************************
	localparam logic [1:0] CS_RC_LOW = 2'h3;
	localparam logic [3:0] TRIG_OFF = 4'h0;
	localparam logic [3:0] TRIG_LAST_EXT = 4'h9;
	localparam logic [3:0] TRIG_RES_READ = 4'hD;
	localparam int NUM_EXT_TRIG = 9;

	// ****************************************
	// timing
	// ****************************************
	localparam int T_CLK_NS = 8;
	localparam int T_INSTR_NS = 32;
	localparam int INSTR_CYC = (T_INSTR_NS + T_CLK_NS - 1) / T_CLK_NS;

	typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_CONV} adcseq_state_t;

endpackage

// file: verif/adcseq_core_model.sv
// stand-in for the analog converter core behind the sequencer
`timescale 1ns/1ns
`default_nettype none
module adcseq_core_model (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic start,
	input wire logic abort,
	input wire logic power,
	input wire logic [7:0] lat,
	input wire logic [9:0] value,
	output logic done,
	output logic [9:0] result
);
	// ****************************************
	// conversion timer
	// ****************************************
	logic [7:0] cnt_q;
	logic busy_q;
	// counts out lat cycles, so the bench sets prompt or slow answers
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= 8'h00;
			busy_q <= 1'b0;
			done <= 1'b0;
			result <= 10'h000;
		end else begin
			done <= 1'b0;
			result <= ~result; // stale result is never held
			if (abort || !power) begin
				busy_q <= 1'b0;
			end else if (start) begin
				busy_q <= 1'b1;
				cnt_q <= lat;
			end else if (busy_q && cnt_q == 8'h00) begin
				busy_q <= 1'b0;
				done <= 1'b1;
				result <= value;
			end else if (busy_q) begin
				cnt_q <= cnt_q - 8'h01;
			end
		end
	end
endmodule
`default_nettype wire

// file: verif/tb.sv
// self-checking bench for the conversion sequencer
`timescale 1ns/1ns
`default_nettype none
module tb;
	logic ref_clk = 0, rst_n = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
	logic [9:0] wb_adr_i = 0;
	logic [3:0] wb_sel_i = 0;
	logic [31:0] wb_dat_i = 0, wb_dat_o, rd;
	logic wb_ack_o, sleep_i = 0, conv_done_i, adc_power_o, conv_start_o;
	logic conv_abort_o, rc_clock_sel_o, wake_req_o;
	logic [8:0] trig_in = 0;
	logic [9:0] conv_result_i, val = 0, v;
	logic [5:0] channel_select_o;
	logic [1:0] positive_ref_select_o;
	logic [7:0] lat = 8'h06;
	logic [32:0] rq[$];
	int fails = 0, comparisons = 0, cyc_n = 0, t_ack, t_start, starts = 0;
	int d0, d1, n0, n, wakes = 0;
	adcseq_top i_dut (.ref_clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i,
		.wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .trig_in,
		.sleep_i, .conv_done_i, .conv_result_i, .adc_power_o, .conv_start_o,
		.conv_abort_o, .rc_clock_sel_o, .channel_select_o,
		.positive_ref_select_o, .wake_req_o);
	adcseq_core_model i_core (.ref_clk, .rst_n, .start(conv_start_o),
		.abort(conv_abort_o), .power(adc_power_o), .lat, .value(val),
		.done(conv_done_i), .result(conv_result_i));
	// ****************************************
	// clock, monitor and helpers
	// ****************************************
	initial begin
		forever #4 ref_clk = ~ref_clk;
	end
	// cycle counter for latency figures
	always @(posedge ref_clk) cyc_n <= cyc_n + 1;
	// watch settled outputs and take the oldest read note
	always @(negedge ref_clk) begin
		if (conv_start_o === 1'b1) begin
			starts++;
			t_start = cyc_n;
		end
		if (wake_req_o === 1'b1) wakes++;
		if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && rq.size() > 0) begin
			if (rq[0][32]) chk(wb_dat_o, rq[0][31:0]);
			void'(rq.pop_front());
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wrap_up();
		$display("fails=%0d comparisons=%0d", fails, comparisons);
		if (fails == 0 && comparisons > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic timeout();
		fails++;
		$display("mismatch at %0t: wait got %h expected %h", $time, 0, 1);
		wrap_up();
	endtask
	task automatic wb(input logic w, input logic [7:0] idx,
		input logic [7:0] d, input logic c, input logic [31:0] e);
		int k;
		k = 0;
		if (!w) rq.push_back({c, e});
		@(posedge ref_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= {idx, 2'b00};
		wb_sel_i <= 4'hf;
		wb_dat_i <= {24'h0, d};
		// ack is looked at on the rising edge that ends the request
		do begin
			@(posedge ref_clk);
			k++;
		end while (wb_ack_o !== 1'b1 && k < 20);
		if (k >= 20) timeout();
		rd = wb_dat_o;
		t_ack = cyc_n;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		wb(1'b1, idx, d, 1'b0, 32'h0);
	endtask
	task automatic rdc(input logic [7:0] idx, input logic [31:0] e);
		wb(1'b0, idx, 8'h00, 1'b1, e);
	endtask
	task automatic poll_done();
		int k;
		k = 0;
		do begin
			wb(1'b0, adcseq_pkg::IDX_CTRL0, 8'h00, 1'b0, 32'h0);
			k++;
		end while (rd[adcseq_pkg::CTRL0_GO] !== 1'b0 && k < 200);
		if (k >= 200) timeout();
	endtask
	task automatic pulse(input logic [8:0] m);
		@(posedge ref_clk);
		trig_in <= m;
		@(posedge ref_clk);
		trig_in <= 9'h000;
		repeat (4) @(posedge ref_clk);
	endtask
	// go with on set, then check the formatted result bytes
	task automatic conv(input logic [7:0] c1, input logic [9:0] x,
		output int d);
		logic [15:0] w;
		int t0;
		w = c1[7] ? {6'h00, x} : {x, 6'h00};
		val <= x;
		wr(adcseq_pkg::IDX_CTRL1, c1);
		wr(adcseq_pkg::IDX_CTRL0, 8'h17);
		t0 = t_ack;
		poll_done();
		d = t_start - t0;
		chk({26'h0, channel_select_o}, 32'h5);
		chk({30'h0, positive_ref_select_o}, {30'h0, c1[1:0]});
		chk({31'h0, rc_clock_sel_o}, {31'h0, c1[5:4] == 2'b11});
		rdc(adcseq_pkg::IDX_RES_LOW, {24'h0, w[7:0]});
		rdc(adcseq_pkg::IDX_RES_HIGH, {24'h0, w[15:8]});
		rdc(adcseq_pkg::IDX_STAT, 32'h1);
	endtask
	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		void'($urandom(44));
		repeat (4) @(posedge ref_clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 6; i++) rdc(adcseq_pkg::IDX_RES_LOW + 8'(i), 0);
		rdc(8'h10, 32'h0);
		wr(adcseq_pkg::IDX_CTRL0, 8'h02);
		rdc(adcseq_pkg::IDX_CTRL0, 32'h0);
		repeat (6) @(posedge ref_clk);
		chk(32'(starts), 32'h0);
		wr(adcseq_pkg::IDX_CTRL0, 8'h15);
		conv(8'h00, 10'($urandom), d0);
		conv(8'h83, 10'($urandom), d0);
		wr(adcseq_pkg::IDX_STAT, 8'h00);
		rdc(adcseq_pkg::IDX_STAT, 32'h0);
		conv(8'hb0, 10'($urandom), d1);
		chk(32'(d1 - d0), 32'(adcseq_pkg::INSTR_CYC));
		conv(8'hf0, 10'($urandom), d1);
		chk(32'(d1 - d0), 32'(adcseq_pkg::INSTR_CYC));
		wr(adcseq_pkg::IDX_CTRL1, 8'h80);
		for (int k = 1; k < 10; k++) begin
			wr(adcseq_pkg::IDX_TRIG, 8'(k));
			n0 = starts;
			pulse(9'h001 << (k - 1));
			poll_done();
			chk(32'(starts - n0), 32'h1);
		end
		wr(adcseq_pkg::IDX_TRIG, 8'h00);
		n0 = starts;
		pulse(9'h1ff);
		chk(32'(starts - n0), 32'h0);
		wr(adcseq_pkg::IDX_TRIG, 8'h0d);
		wb(1'b0, adcseq_pkg::IDX_RES_HIGH, 8'h00, 1'b0, 32'h0);
		repeat (4) @(posedge ref_clk);
		poll_done();
		chk(32'(starts - n0), 32'h1);
		wr(adcseq_pkg::IDX_TRIG, 8'h00);
		lat <= 8'h3c;
		wr(adcseq_pkg::IDX_CTRL0, 8'h17);
		repeat (6) @(posedge ref_clk);
		sleep_i <= 1'b1;
		n = 0;
		do begin
			@(negedge ref_clk);
			n++;
		end while (conv_abort_o !== 1'b1 && n < 10);
		if (n >= 10) timeout();
		repeat (3) @(negedge ref_clk);
		chk({31'h0, adc_power_o}, 32'h0);
		@(posedge ref_clk);
		sleep_i <= 1'b0;
		rdc(adcseq_pkg::IDX_CTRL0, 32'h15);
		wr(adcseq_pkg::IDX_STAT, 8'h02);
		wr(adcseq_pkg::IDX_CTRL1, 8'hb0);
		wr(adcseq_pkg::IDX_CTRL0, 8'h17);
		sleep_i <= 1'b1;
		n = 0;
		do begin
			@(negedge ref_clk);
			n++;
		end while (wake_req_o !== 1'b1 && n < 200);
		chk(32'(n < 200), 32'h1);
		@(posedge ref_clk);
		sleep_i <= 1'b0;
		// rc sleep conversion with irq off powers down, no wake
		wr(adcseq_pkg::IDX_STAT, 8'h00);
		wr(adcseq_pkg::IDX_CTRL0, 8'h17);
		sleep_i <= 1'b1;
		n0 = wakes;
		n = 0;
		do begin
			@(negedge ref_clk);
			n++;
		end while (adc_power_o !== 1'b0 && n < 200);
		chk(32'(n < 200), 32'h1);
		repeat (4) @(negedge ref_clk);
		chk({31'h0, adc_power_o}, 32'h0);
		chk(32'(wakes - n0), 32'h0);
		@(posedge ref_clk);
		sleep_i <= 1'b0;
		rdc(adcseq_pkg::IDX_STAT, 32'h1);
		rdc(adcseq_pkg::IDX_CTRL0, 32'h15);
		lat <= 8'h06;
		wr(adcseq_pkg::IDX_CTRL1, 8'h80);
		wr(adcseq_pkg::IDX_TRIG, 8'h01);
		n0 = starts;
		sleep_i <= 1'b1;
		pulse(9'h001);
		pulse(9'h001);
		chk(32'(starts - n0), 32'h0);
		sleep_i <= 1'b0;
		repeat (4) @(posedge ref_clk);
		poll_done();
		repeat (20) @(posedge ref_clk);
		chk(32'(starts - n0), 32'h1);
		wrap_up();
	end
	// cut a hang short
	initial begin
		repeat (90000) @(posedge ref_clk);
		timeout();
	end
endmodule
`default_nettype wire
